// ### rtl/kpc_defs.svh
// Register addresses, banks, field positions and reset values of the keypad port.
`ifndef KPC_DEFS_SVH
`define KPC_DEFS_SVH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define KPC_PORT_W        8
`define KPC_ADDR_W        8
`define KPC_BANK_W        4

// ----------------------------------------------------------------------
// Register addresses and banks
// ----------------------------------------------------------------------
`define KPC_ADDR_PORT_A_WITH_PULLUP_CTL    8'h10
`define KPC_ADDR_DIR      8'h11
`define KPC_ADDR_LATCH    8'h12
`define KPC_ADDR_FLAGS    8'h16
`define KPC_ADDR_ENABLES  8'h17
`define KPC_BANK_PORT     4'h0
`define KPC_BANK_IRQ      4'h1

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define KPC_PULLUP_BIT    7
`define KPC_CHANGE_BIT    7
`define KPC_CAP_ONE_BIT   0
`define KPC_CAP_TWO_BIT   1
`define KPC_PWM_ONE_BIT   2
`define KPC_PWM_TWO_BIT   3
`define KPC_TIMER_ONE_TWO_EXT_CLOCK_BIT    4
`define KPC_TIMER_THREE_EXT_CLOCK_BIT     5

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define KPC_RST_DIR       8'hff
`define KPC_RST_LATCH     8'h00
`define KPC_RST_FLAGS     8'h02
`define KPC_RST_ENABLES   8'h00
`define KPC_RST_ZERO      8'h00
`define KPC_RST_PULLUP    1'b0

`endif

// ### rtl/kpc_pkg.sv
// Types shared by the keypad port modules.
package kpc_pkg;

   typedef logic [7:0] kpc_byte_t;

   typedef enum logic [2:0] {
      KPC_SEL_NONE,
      KPC_SEL_PORT_A_WITH_PULLUP_CTL,
      KPC_SEL_DIR,
      KPC_SEL_LATCH,
      KPC_SEL_FLAGS,
      KPC_SEL_ENABLES
   } kpc_sel_e;

endpackage

// ### rtl/kpc_port.sv
// Eight-pin keypad port with pull-ups, change detection and pin sharing.
`include "kpc_defs.svh"

module kpc_port
   import kpc_pkg::*;
(
   // Clock and reset
   input  wire logic                    REF_CLK,
   input  wire logic                    ARST_N,
   // Core register file access
   input  wire logic [`KPC_ADDR_W-1:0]  REG_ADDR,
   input  wire logic [`KPC_BANK_W-1:0]  BANK_SELECT,
   input  wire logic                    REG_WR,
   input  wire logic                    REG_RD,
   input  wire logic [`KPC_PORT_W-1:0]  REG_WDATA,
   output logic      [`KPC_PORT_W-1:0]  REG_RDATA,
   output logic                         REG_RVALID,
   // Keypad pins
   input  wire logic [`KPC_PORT_W-1:0]  KEYPAD_PINS_I,
   output logic      [`KPC_PORT_W-1:0]  KEYPAD_PINS_O,
   output logic      [`KPC_PORT_W-1:0]  KEYPAD_PINS_OE,
   output logic      [`KPC_PORT_W-1:0]  KEYPAD_PULLUP_EN,
   // Shared peripheral functions
   input  wire logic                    PWM_ONE_ON,
   input  wire logic                    PWM_TWO_ON,
   input  wire logic                    PWM_OUT_ONE,
   input  wire logic                    PWM_OUT_TWO,
   output logic                         CAPTURE_IN_ONE,
   output logic                         CAPTURE_IN_TWO,
   output logic                         TIMER_ONE_TWO_EXT_CLOCK,
   output logic                         TIMER_THREE_EXT_CLOCK,
   // Change interrupt and wake
   output logic                         CHANGE_FLAG,
   output logic                         CHANGE_IRQ,
   output logic                         CHANGE_WAKE
);

   // ----------------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------------
   logic                    pullup_disable_n_q;
   logic                    pullup_disable_n_d;
   kpc_byte_t               keypad_direction_q;
   kpc_byte_t               keypad_direction_d;
   kpc_byte_t               keypad_port_q;
   kpc_byte_t               keypad_port_d;
   logic                    change_flag_q;
   logic                    change_flag_d;
   logic [6:0]              flags_other_q;
   logic [6:0]              flags_other_d;
   kpc_byte_t               periph_irq_enables_q;
   kpc_byte_t               periph_irq_enables_d;
   kpc_byte_t               pins_sync;
   kpc_byte_t               mismatch;
   kpc_byte_t               pin_o_d;
   kpc_byte_t               pin_oe_d;
   kpc_byte_t               rdata_d;
   kpc_sel_e                sel;
   logic                    change_irq_enable;

   // The flag register reset value covers both the change flag and the
   // plain storage bits beside it.
   localparam kpc_byte_t    flags_rst = `KPC_RST_FLAGS;

   // ----------------------------------------------------------------------
   // Pin synchroniser
   // ----------------------------------------------------------------------
   // sync pin levels
   kpc_sync #(
      .WIDTH (`KPC_PORT_W)
   ) u_pin_sync (
      .clk    (REF_CLK),
      .arst_n (ARST_N),
      .d      (KEYPAD_PINS_I),
      .q      (pins_sync)
   );

   // ----------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------
   // bank qualified decode
   always_comb begin
      sel = KPC_SEL_NONE;
      if (BANK_SELECT == `KPC_BANK_PORT) begin
         case (REG_ADDR)
            `KPC_ADDR_PORT_A_WITH_PULLUP_CTL: sel = KPC_SEL_PORT_A_WITH_PULLUP_CTL;
            `KPC_ADDR_DIR:   sel = KPC_SEL_DIR;
            `KPC_ADDR_LATCH: sel = KPC_SEL_LATCH;
            default:         sel = KPC_SEL_NONE;
         endcase
      end else if (BANK_SELECT == `KPC_BANK_IRQ) begin
         case (REG_ADDR)
            `KPC_ADDR_FLAGS:   sel = KPC_SEL_FLAGS;
            `KPC_ADDR_ENABLES: sel = KPC_SEL_ENABLES;
            default:           sel = KPC_SEL_NONE;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Pull-up control bit
   // ----------------------------------------------------------------------
   // shared pull-up control
   always_comb begin
      pullup_disable_n_d = pullup_disable_n_q;
      if (REG_WR && sel == KPC_SEL_PORT_A_WITH_PULLUP_CTL) begin
         pullup_disable_n_d = REG_WDATA[`KPC_PULLUP_BIT];
      end
   end

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pullup_disable_n_q <= `KPC_RST_PULLUP;
      end else begin
         pullup_disable_n_q <= pullup_disable_n_d;
      end
   end

   // ----------------------------------------------------------------------
   // Direction register
   // ----------------------------------------------------------------------
   // one selects input
   always_comb begin
      keypad_direction_d = keypad_direction_q;
      if (REG_WR && sel == KPC_SEL_DIR) begin
         keypad_direction_d = REG_WDATA;
      end
   end

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         keypad_direction_q <= `KPC_RST_DIR;
      end else begin
         keypad_direction_q <= keypad_direction_d;
      end
   end

   // ----------------------------------------------------------------------
   // Output latch
   // ----------------------------------------------------------------------
   // latch written regardless
   always_comb begin
      keypad_port_d = keypad_port_q;
      if (REG_WR && sel == KPC_SEL_LATCH) begin
         keypad_port_d = REG_WDATA;
      end
   end

   // The latch powers up cleared so the pins never drive an unknown level.
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         keypad_port_q <= `KPC_RST_LATCH;
      end else begin
         keypad_port_q <= keypad_port_d;
      end
   end

   // ----------------------------------------------------------------------
   // Pin drivers and pull-ups
   // ----------------------------------------------------------------------
   // drive outputs from latch
   always_comb begin
      pin_o_d  = keypad_port_q;
      pin_oe_d = ~keypad_direction_q;
      if (PWM_ONE_ON) begin
         pin_o_d[`KPC_PWM_ONE_BIT]  = PWM_OUT_ONE;
         pin_oe_d[`KPC_PWM_ONE_BIT] = 1'b1;
      end
      if (PWM_TWO_ON) begin
         pin_o_d[`KPC_PWM_TWO_BIT]  = PWM_OUT_TWO;
         pin_oe_d[`KPC_PWM_TWO_BIT] = 1'b1;
      end
   end

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         KEYPAD_PINS_O  <= `KPC_RST_ZERO;
         KEYPAD_PINS_OE <= `KPC_RST_ZERO;
      end else begin
         KEYPAD_PINS_O  <= pin_o_d;
         KEYPAD_PINS_OE <= pin_oe_d;
      end
   end

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         KEYPAD_PULLUP_EN <= `KPC_RST_ZERO;
      end else begin
         KEYPAD_PULLUP_EN <= {`KPC_PORT_W{~pullup_disable_n_q}} & ~pin_oe_d;
      end
   end

   // ----------------------------------------------------------------------
   // Change detection
   // ----------------------------------------------------------------------
   // mask output pins
   assign mismatch = keypad_direction_q & (pins_sync ^ keypad_port_q);

   // A set in the same cycle as a software clear wins, so an ongoing
   // mismatch can never be cleared away.
   // OR sets change flag
   always_comb begin
      change_flag_d = change_flag_q;
      if (REG_WR && sel == KPC_SEL_FLAGS) begin
         change_flag_d = REG_WDATA[`KPC_CHANGE_BIT];
      end
      if (|mismatch) begin
         change_flag_d = 1'b1;
      end
   end

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         change_flag_q <= flags_rst[`KPC_CHANGE_BIT];
      end else begin
         change_flag_q <= change_flag_d;
      end
   end

   // ----------------------------------------------------------------------
   // Flag and enable registers
   // ----------------------------------------------------------------------
   // The other flag bits belong to neighbouring peripherals; here they
   // are plain storage so the register reads back as written.
   always_comb begin
      flags_other_d        = flags_other_q;
      periph_irq_enables_d = periph_irq_enables_q;
      if (REG_WR && sel == KPC_SEL_FLAGS) begin
         flags_other_d = REG_WDATA[6:0];
      end
      if (REG_WR && sel == KPC_SEL_ENABLES) begin
         periph_irq_enables_d = REG_WDATA;
      end
   end

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         flags_other_q        <= flags_rst[6:0];
         periph_irq_enables_q <= `KPC_RST_ENABLES;
      end else begin
         flags_other_q        <= flags_other_d;
         periph_irq_enables_q <= periph_irq_enables_d;
      end
   end

   assign change_irq_enable = periph_irq_enables_q[`KPC_CHANGE_BIT];

   // ----------------------------------------------------------------------
   // Interrupt and wake outputs
   // ----------------------------------------------------------------------
   // wake on change
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         CHANGE_FLAG <= 1'b0;
         CHANGE_IRQ  <= 1'b0;
         CHANGE_WAKE <= 1'b0;
      end else begin
         CHANGE_FLAG <= change_flag_d;
         CHANGE_IRQ  <= change_flag_d & change_irq_enable;
         CHANGE_WAKE <= change_flag_d & change_irq_enable;
      end
   end

   // ----------------------------------------------------------------------
   // Alternate input functions
   // ----------------------------------------------------------------------
   // Peripherals see the pin itself, so a pin set as output drives its
   // own capture or timer input.
   // capture inputs
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         CAPTURE_IN_ONE          <= 1'b0;
         CAPTURE_IN_TWO          <= 1'b0;
         TIMER_ONE_TWO_EXT_CLOCK <= 1'b0;
         TIMER_THREE_EXT_CLOCK   <= 1'b0;
      end else begin
         CAPTURE_IN_ONE          <= pins_sync[`KPC_CAP_ONE_BIT];
         CAPTURE_IN_TWO          <= pins_sync[`KPC_CAP_TWO_BIT];
         TIMER_ONE_TWO_EXT_CLOCK <= pins_sync[`KPC_TIMER_ONE_TWO_EXT_CLOCK_BIT];
         TIMER_THREE_EXT_CLOCK   <= pins_sync[`KPC_TIMER_THREE_EXT_CLOCK_BIT];
      end
   end

   // ----------------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------------
   // Unused bits of the pull-up control register read as zero.
   // read pin levels
   always_comb begin
      rdata_d = `KPC_RST_ZERO;
      unique case (sel)
         KPC_SEL_PORT_A_WITH_PULLUP_CTL: begin
            rdata_d[`KPC_PULLUP_BIT] = pullup_disable_n_q;
         end
         KPC_SEL_DIR:     rdata_d = keypad_direction_q;
         KPC_SEL_LATCH:   rdata_d = pins_sync;
         KPC_SEL_FLAGS:   rdata_d = {change_flag_q, flags_other_q};
         KPC_SEL_ENABLES: rdata_d = periph_irq_enables_q;
         KPC_SEL_NONE:    rdata_d = `KPC_RST_ZERO;
      endcase
   end

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         REG_RDATA  <= `KPC_RST_ZERO;
         REG_RVALID <= 1'b0;
      end else begin
         REG_RVALID <= REG_RD;
         if (REG_RD) begin
            REG_RDATA <= rdata_d;
         end
      end
   end

endmodule

// ### rtl/kpc_sync.sv
// Two flip-flop synchroniser for a group of asynchronous inputs.
module kpc_sync #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             arst_n,
   // Data
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_q;

   // The first stage feeds only the second stage.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule

// ### test/kpc_keypad_model.sv
// Behavioural keypad board that resolves the eight pin levels.
module kpc_keypad_model
   import kpc_pkg::*;
(
   // Clock
   input  wire logic      clk,
   // Port side of the pins
   input  wire kpc_byte_t pin_o,
   input  wire kpc_byte_t pin_oe,
   input  wire kpc_byte_t pull_en,
   // Keys, high while pressed
   input  wire kpc_byte_t keys,
   output kpc_byte_t      level
);
   timeunit 1ns;
   timeprecision 1ns;
   kpc_byte_t float_q = 8'h00;
   // An undriven pin has no level, so it wanders rather than hold a value.
   always @(posedge clk)
      float_q <= ~float_q;
   // A pressed key shorts the pin to ground and beats a driving output.
   always_comb begin
      for (int i = 0; i < 8; i++)
         level[i] = keys[i] ? 1'b0 : pin_oe[i] ? pin_o[i] :
                    pull_en[i] ? 1'b1 : float_q[i];
   end
endmodule

// ### test/kpc_port_properties.sv
// Port-level assertions for the keypad port, bound to its top module.
`include "kpc_defs.svh"
module kpc_port_checker (
   // Clock and reset
   input wire logic                   REF_CLK,
   input wire logic                   ARST_N,
   // Register access
   input wire logic [`KPC_ADDR_W-1:0] REG_ADDR,
   input wire logic [`KPC_BANK_W-1:0] BANK_SELECT,
   input wire logic                   REG_WR,
   input wire logic                   REG_RD,
   input wire logic [`KPC_PORT_W-1:0] REG_WDATA,
   input wire logic [`KPC_PORT_W-1:0] REG_RDATA,
   input wire logic                   REG_RVALID,
   // Pins and shared functions
   input wire logic [`KPC_PORT_W-1:0] KEYPAD_PINS_I,
   input wire logic [`KPC_PORT_W-1:0] KEYPAD_PINS_O,
   input wire logic [`KPC_PORT_W-1:0] KEYPAD_PINS_OE,
   input wire logic [`KPC_PORT_W-1:0] KEYPAD_PULLUP_EN,
   input wire logic                   PWM_ONE_ON,
   input wire logic                   PWM_OUT_ONE,
   input wire logic                   CAPTURE_IN_ONE,
   input wire logic                   CAPTURE_IN_TWO,
   input wire logic                   TIMER_ONE_TWO_EXT_CLOCK,
   input wire logic                   TIMER_THREE_EXT_CLOCK,
   // Change interrupt
   input wire logic                   CHANGE_FLAG,
   input wire logic                   CHANGE_IRQ,
   input wire logic                   CHANGE_WAKE
);
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!ARST_N);

   // Pin levels only count once they have been still for a while, so
   // the synchroniser delay never decides a check.
   logic [`KPC_PORT_W-1:0] prev_q;
   logic [2:0]             still_q;
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         prev_q  <= 8'h00;
         still_q <= 3'h0;
      end else begin
         prev_q <= KEYPAD_PINS_I;
         if (KEYPAD_PINS_I != prev_q)
            still_q <= 3'h0;
         else if (still_q != 3'h7)
            still_q <= still_q + 3'h1;
      end
   end

   sequence s_latch_wr;
      REG_WR && REG_ADDR == 8'h12 && BANK_SELECT == 4'h0;
   endsequence
   sequence s_quiet;
      !REG_WR [*3];
   endsequence

   AST_LATCH_DRIVE: assert property (s_latch_wr ##1 s_quiet |->
      ((KEYPAD_PINS_O ^ $past(REG_WDATA, 3)) & KEYPAD_PINS_OE & 8'hf3) == 0)
      else $error("pin drive differs from written latch");
   AST_PU_OUTPUT: assert property (
      (KEYPAD_PULLUP_EN & KEYPAD_PINS_OE) == 8'h00)
      else $error("pull-up on while pin drives");
   AST_PU_RESET: assert property (
      ARST_N && !$past(ARST_N) |=> KEYPAD_PULLUP_EN == 8'hff)
      else $error("pull-ups not on after reset");
   AST_READ_PINS: assert property (
      REG_RD && REG_ADDR == 8'h12 && BANK_SELECT == 4'h0 && still_q >= 4
      |=> REG_RVALID && REG_RDATA == $past(prev_q))
      else $error("port read differs from pin levels");
   AST_WRONG_BANK: assert property (
      REG_RD && BANK_SELECT > 4'h1 |=> REG_RVALID && REG_RDATA == 8'h00)
      else $error("read outside banks not zero");
   AST_SHARED_IN: assert property (still_q >= 4 |->
      {TIMER_THREE_EXT_CLOCK, TIMER_ONE_TWO_EXT_CLOCK, CAPTURE_IN_TWO,
       CAPTURE_IN_ONE} == {prev_q[5], prev_q[4], prev_q[1], prev_q[0]})
      else $error("shared input differs from pin");
   AST_PWM_ONE: assert property (
      (PWM_ONE_ON && $stable(PWM_OUT_ONE)) [*3]
      |-> KEYPAD_PINS_OE[2] && KEYPAD_PINS_O[2] == PWM_OUT_ONE)
      else $error("pin two not carrying PWM");
   AST_IRQ_FLAG: assert property (CHANGE_IRQ |-> CHANGE_FLAG)
      else $error("change request without flag");
   AST_WAKE: assert property (CHANGE_WAKE == CHANGE_IRQ)
      else $error("wake differs from change request");
endmodule

bind kpc_port kpc_port_checker i_chk (
   .REF_CLK, .ARST_N, .REG_ADDR, .BANK_SELECT, .REG_WR, .REG_RD,
   .REG_WDATA, .REG_RDATA, .REG_RVALID, .KEYPAD_PINS_I, .KEYPAD_PINS_O,
   .KEYPAD_PINS_OE, .KEYPAD_PULLUP_EN, .PWM_ONE_ON, .PWM_OUT_ONE,
   .CAPTURE_IN_ONE, .CAPTURE_IN_TWO, .TIMER_ONE_TWO_EXT_CLOCK,
   .TIMER_THREE_EXT_CLOCK, .CHANGE_FLAG, .CHANGE_IRQ, .CHANGE_WAKE
);

// ### test/kpc_port_tb_top.sv
// Self-checking bench for the keypad port with its keypad model.
module kpc_port_tb_top
   import kpc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [7:0] a; logic [3:0] b; kpc_byte_t d, e;} kpc_row_s;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [3:0] bank = 4'h0;
   logic       wr_en = 1'b0, rd_en = 1'b0, rvalid;
   logic       pw1_on = 1'b0, pw2_on = 1'b0, pw1 = 1'b0, pw2 = 1'b0;
   logic       capture_in_one, capture_in_two, timer_one_two_ext_clock, timer_three_ext_clock, flag, irq, wake;
   kpc_byte_t  wdata = 8'h00, keys = 8'h00, rdata, d;
   kpc_byte_t  pin_i, pin_o, pin_oe, pull_en;
   int         miscompares = 0, total_checks = 0, cycles = 0;
   kpc_row_s   rows[9] = '{'{8'h11, 4'h0, 8'h5a, 8'h5a},
      '{8'h10, 4'h0, 8'hff, 8'h80}, '{8'h10, 4'h0, 8'h00, 8'h00},
      '{8'h17, 4'h1, 8'hc3, 8'hc3}, '{8'h17, 4'h1, 8'h00, 8'h00},
      '{8'h11, 4'h1, 8'ha5, 8'h00}, '{8'h16, 4'h0, 8'h7f, 8'h00},
      '{8'h12, 4'h2, 8'hff, 8'h00}, '{8'h11, 4'h0, 8'hff, 8'hff}};

   always #50 clk = ~clk;

   kpc_port i_dut (.REF_CLK(clk), .ARST_N(rst_n), .REG_ADDR(addr),
      .BANK_SELECT(bank), .REG_WR(wr_en), .REG_RD(rd_en), .REG_WDATA(wdata),
      .REG_RDATA(rdata), .REG_RVALID(rvalid), .KEYPAD_PINS_I(pin_i),
      .KEYPAD_PINS_O(pin_o), .KEYPAD_PINS_OE(pin_oe),
      .KEYPAD_PULLUP_EN(pull_en), .PWM_ONE_ON(pw1_on), .PWM_TWO_ON(pw2_on),
      .PWM_OUT_ONE(pw1), .PWM_OUT_TWO(pw2), .CAPTURE_IN_ONE(capture_in_one),
      .CAPTURE_IN_TWO(capture_in_two), .TIMER_ONE_TWO_EXT_CLOCK(timer_one_two_ext_clock),
      .TIMER_THREE_EXT_CLOCK(timer_three_ext_clock), .CHANGE_FLAG(flag), .CHANGE_IRQ(irq),
      .CHANGE_WAKE(wake));
   kpc_keypad_model i_keys (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe),
      .pull_en(pull_en), .keys(keys), .level(pin_i));

   // ---------------
   // Bench tasks
   // ---------------
   task automatic final_report();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic cmp(input kpc_byte_t got, input kpc_byte_t exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [3:0] b, input kpc_byte_t v);
      @(posedge clk);
      addr  <= a;
      bank  <= b;
      wdata <= v;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [3:0] b, output kpc_byte_t v);
      @(posedge clk);
      addr  <= a;
      bank  <= b;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      v = rvalid ? rdata : 8'hxx;
   endtask
   task automatic chk(input logic [7:0] a, input logic [3:0] b, input kpc_byte_t e);
      kpc_byte_t v;
      rd(a, b, v);
      cmp(v, e);
   endtask
   task automatic do_reset();
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      tick(1);
   endtask

   // A hung handshake would stall the run, so cycles are capped well above need.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         miscompares++;
         final_report();
      end
   end

   // ---------------
   // Main sequence
   // ---------------
   initial begin
      do_reset();
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].b, rows[i].d);
         chk(rows[i].a, rows[i].b, rows[i].e);
      end
      do_reset();
      cmp(pull_en, 8'hff);
      cmp(pin_oe, 8'h00);
      chk(8'h10, 4'h0, 8'h00);
      chk(8'h11, 4'h0, 8'hff);
      chk(8'h17, 4'h1, 8'h00);
      rd(8'h16, 4'h1, d);
      cmp(d & 8'h7f, 8'h02);
      wr(8'h12, 4'h0, 8'h3c);
      wr(8'h11, 4'h0, 8'h00);
      tick(1);
      cmp(pin_oe, 8'hff);
      cmp(pin_o, 8'h3c);
      cmp(pull_en, 8'h00);
      wr(8'h12, 4'h0, 8'ha5);
      tick(3);
      cmp(pin_o, 8'ha5);
      chk(8'h12, 4'h0, 8'ha5);
      wr(8'h11, 4'h0, 8'hff);
      tick(3);
      chk(8'h12, 4'h0, 8'hff);
      wr(8'h10, 4'h0, 8'h80);
      tick(1);
      cmp(pull_en, 8'h00);
      wr(8'h10, 4'h0, 8'h00);
      tick(1);
      cmp(pull_en, 8'hff);
      // whole port as inputs for wake
      wr(8'h12, 4'h0, 8'hff);
      wr(8'h17, 4'h1, 8'h80);
      wr(8'h16, 4'h1, 8'h00);
      tick(1);
      cmp({5'h00, wake, irq, flag}, 8'h00);
      @(posedge clk);
      keys <= 8'h08;
      tick(3);
      cmp({5'h00, wake, irq, flag}, 8'h07);
      wr(8'h16, 4'h1, 8'h00);
      tick(1);
      cmp({5'h00, wake, irq, flag}, 8'h07);
      rd(8'h12, 4'h0, d);
      cmp(d, 8'hf7);
      wr(8'h12, 4'h0, d);
      wr(8'h16, 4'h1, 8'h00);
      tick(1);
      cmp({5'h00, wake, irq, flag}, 8'h00);
      wr(8'h11, 4'h0, 8'hf7);
      wr(8'h12, 4'h0, 8'hff);
      wr(8'h16, 4'h1, 8'h00);
      tick(3);
      cmp({7'h00, flag}, 8'h00);
      wr(8'h11, 4'h0, 8'hff);
      tick(3);
      cmp({7'h00, flag}, 8'h01);
      wr(8'h17, 4'h1, 8'h00);
      tick(1);
      cmp({5'h00, wake, irq, flag}, 8'h01);
      @(posedge clk);
      keys   <= 8'h11;
      pw1_on <= 1'b1;
      pw2_on <= 1'b1;
      pw1    <= 1'b1;
      tick(4);
      cmp(pin_oe & 8'h0c, 8'h0c);
      cmp(pin_o & 8'h0c, 8'h04);
      cmp({4'h0, timer_three_ext_clock, timer_one_two_ext_clock, capture_in_two, capture_in_one}, 8'h0a);
      @(posedge clk);
      pw1_on <= 1'b0;
      pw2_on <= 1'b0;
      tick(1);
      cmp(pin_oe & 8'h0c, 8'h00);
      final_report();
   end
endmodule
